// ==== sea_autoload.sv ====
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - both straps low selects memory master mode
// - memory mode drives clock, data bidirectional
// - straps low then high select slave mode
// - slave mode: clock input, data always released
// - load continues only on signature 1516h
// - region code in byte 02h sets stop
// - byte 03h bit0 protects legacy alias enable
module sea_autoload import sea_pkg::*; #(
  parameter int QTR_CYC = SEA_QTR_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Strap pins
  input wire logic iface_select_strap_high_i,
  input wire logic iface_select_strap_low_i,
  // Clock pin (pin 4)
  input wire logic smbclk_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  // Data pin (pin 6)
  input wire logic eeprom_serial_data_i,
  output logic eeprom_serial_data_o,
  output logic eeprom_serial_data_oe_n_o,
  // Configuration write port
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_data_o,
  // Status
  output logic load_done_o,
  output logic legacy_io_alias_wp_o,
  output logic mode_smbus_o
);
  localparam logic [15:0] QTR_M1 = 16'(QTR_CYC - 1);

  // Synchronised pin levels
  logic [1:0] strap_s;
  logic smbclk_s;
  logic sda_s;
  sea_sync2 #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({iface_select_strap_high_i, iface_select_strap_low_i, smbclk_i, eeprom_serial_data_i}),
    .q_o({strap_s, smbclk_s, sda_s})
  );

  // Stop address for a region code; undefined codes take the smallest region
  function automatic logic [7:0] stop_of(input logic [3:0] code);
    unique case (code)
      SEA_RGN_G2: stop_of = SEA_STOP_G2;
      SEA_RGN_G3: stop_of = SEA_STOP_G3;
      SEA_RGN_G4: stop_of = SEA_STOP_G4;
      default: stop_of = SEA_STOP_G1;
    endcase
  endfunction

  // Image address to configuration offset
  function automatic logic [7:0] map_of(input logic [7:0] ee);
    if (ee <= SEA_ID_END) begin
      map_of = ee - SEA_ID_SHIFT;
    end else if (ee == SEA_CAP_EE) begin
      map_of = SEA_CAP_CFG;
    end else begin
      map_of = ee;
    end
  endfunction

  // Mode capture, once after reset release
  sea_mode_t mode_reg, mode_next;
  logic cap_reg, cap_next;
  always_comb begin
    mode_next = mode_reg;
    cap_next = 1'b1;
    if (!cap_reg) begin
      if (strap_s == SEA_STRAP_EE) begin
        mode_next = SEA_MODE_EE;
      end else if (strap_s == SEA_STRAP_SMB) begin
        mode_next = SEA_MODE_SMB;
      end else begin
        mode_next = SEA_MODE_NONE;
      end
    end
  end
  // Waits two cycles so the straps have crossed the synchroniser
  // The synchroniser leaves reset at zero; an earlier capture would see that, not the pins
  logic [1:0] cap_wait_reg; // Shifts in ones; top bit marks valid strap levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= SEA_MODE_NONE;
      cap_reg <= 1'b0;
      cap_wait_reg <= 2'h0;
    end else begin
      cap_wait_reg <= {cap_wait_reg[0], 1'b1};
      if (cap_wait_reg[1]) begin
        mode_reg <= mode_next;
        cap_reg <= cap_next;
      end
    end
  end

  // Load engine state
  sea_state_t st_reg, st_next;
  sea_step_t sq_reg, sq_next;
  logic [1:0] q_reg, q_next; // Quarter of a bit
  logic [15:0] div_reg, div_next;
  logic [3:0] bitn_reg, bitn_next; // 8 is the acknowledge slot
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ee_reg, ee_next;
  logic [7:0] lim_reg, lim_next;
  logic [7:0] sig_lo_reg, sig_lo_next;
  logic [3:0] rgn_reg, rgn_next;
  logic ackb_reg, ackb_next, last_reg, last_next, sig_reg, sig_next;
  logic nack_reg, nack_next, wp_next, done_next, pend_reg, pend_next;
  logic scl_next, scl_oe_n_next, sda_oe_n_next, wr_next, go_reg, go_next;
  logic [7:0] caddr_next, cdata_next;
  logic tick, cont;
  assign tick = (div_reg == 16'h0000);
  // Whether to read on past the byte just received
  always_comb begin
    cont = (ee_reg != SEA_LAST_ADDR);
    if (ee_reg == SEA_SIG_HI_ADDR && {sh_reg, sig_lo_reg} != SEA_SIG) begin
      cont = 1'b0;
    end
    if (ee_reg > SEA_MISC_ADDR && ee_reg >= lim_reg) begin
      cont = 1'b0;
    end
  end

  // Next-state logic of the engine
  always_comb begin
    st_next = st_reg;
    sq_next = sq_reg;
    q_next = q_reg;
    div_next = tick ? QTR_M1 : div_reg - 16'h0001;
    bitn_next = bitn_reg;
    sh_next = sh_reg;
    ee_next = ee_reg;
    lim_next = lim_reg;
    sig_lo_next = sig_lo_reg;
    rgn_next = rgn_reg;
    ackb_next = ackb_reg;
    last_next = last_reg;
    sig_next = sig_reg;
    nack_next = nack_reg;
    wp_next = legacy_io_alias_wp_o;
    done_next = load_done_o;
    pend_next = pend_reg & ~go_reg;
    scl_next = scl_o;
    sda_oe_n_next = eeprom_serial_data_oe_n_o;
    scl_oe_n_next = (mode_reg != SEA_MODE_EE);
    wr_next = 1'b0;
    caddr_next = cfg_addr_o;
    cdata_next = cfg_data_o;
    unique case (st_reg)
      SEA_IDLE: begin
        scl_next = 1'b1;
        sda_oe_n_next = 1'b1; // Released; in slave mode it stays so
        if (cap_reg && mode_reg == SEA_MODE_EE && (pend_reg || go_reg)) begin
          st_next = SEA_START;
          sq_next = SEA_SQ_DEVW;
          sh_next = SEA_DEV_WR;
          q_next = 2'h0;
          pend_next = 1'b0;
          done_next = 1'b0;
          sig_next = 1'b0;
          nack_next = 1'b0;
          wp_next = 1'b0;
          lim_next = SEA_STOP_G1;
        end
      end
      SEA_START: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: sda_oe_n_next = 1'b1;
          2'h1: scl_next = 1'b1;
          2'h2: sda_oe_n_next = 1'b0; // Data falls while clock high
          default: begin
            scl_next = 1'b0;
            st_next = SEA_BIT;
            bitn_next = 4'h0;
          end
        endcase
      end
      SEA_BIT: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: begin
            if (bitn_reg != 4'h8) begin
              sda_oe_n_next = (sq_reg == SEA_SQ_READ) | sh_reg[7];
            end else if (sq_reg != SEA_SQ_READ) begin
              sda_oe_n_next = 1'b1; // Free slot for the memory's ack
            end else begin
              sda_oe_n_next = ~cont; // Nack ends the read
              last_next = ~cont;
              if (ee_reg == SEA_START_ADDR) begin
                sig_lo_next = sh_reg;
              end else if (ee_reg == SEA_SIG_HI_ADDR) begin
                sig_next = cont;
              end else if (ee_reg == SEA_REGION_ADDR) begin
                rgn_next = sh_reg[SEA_REGION_LSB +: 4];
                lim_next = stop_of(sh_reg[SEA_REGION_LSB +: 4]);
              end else if (ee_reg == SEA_MISC_ADDR) begin
                wp_next = sh_reg[SEA_WP_BIT];
              end else begin
                wr_next = 1'b1;
                caddr_next = map_of(ee_reg);
                cdata_next = sh_reg;
              end
            end
          end
          2'h1: scl_next = 1'b1;
          2'h2: begin
            if (bitn_reg != 4'h8) begin
              sh_next = {sh_reg[6:0], sda_s}; // Shifts out and in alike
            end else begin
              ackb_next = sda_s;
            end
          end
          default: begin
            scl_next = 1'b0;
            bitn_next = bitn_reg + 4'h1;
            if (bitn_reg == 4'h8) begin
              bitn_next = 4'h0;
              if (sq_reg == SEA_SQ_READ) begin
                if (last_reg) begin
                  st_next = SEA_STOP;
                end else begin
                  ee_next = ee_reg + 8'h01;
                end
              end else if (ackb_reg) begin
                nack_next = 1'b1; // Memory absent or busy
                st_next = SEA_STOP;
              end else if (sq_reg == SEA_SQ_DEVW) begin
                sq_next = SEA_SQ_WADR;
                sh_next = SEA_START_ADDR;
              end else if (sq_reg == SEA_SQ_WADR) begin
                sq_next = SEA_SQ_DEVR;
                sh_next = SEA_DEV_RD;
                st_next = SEA_START; // Repeated start
              end else begin
                sq_next = SEA_SQ_READ;
                ee_next = SEA_START_ADDR;
              end
            end
          end
        endcase
      end
      SEA_STOP: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: sda_oe_n_next = 1'b0;
          2'h1: scl_next = 1'b1;
          2'h2: sda_oe_n_next = 1'b1; // Data rises while clock high
          default: st_next = SEA_DONE;
        endcase
      end
      default: begin
        done_next = 1'b1;
        st_next = SEA_IDLE;
      end
    endcase
    if (mode_reg != SEA_MODE_EE) begin
      sda_oe_n_next = 1'b1;
    end
  end

  // Register the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= SEA_IDLE;
      sq_reg <= SEA_SQ_DEVW;
      q_reg <= 2'h0;
      div_reg <= 16'h0000;
      bitn_reg <= 4'h0;
      sh_reg <= 8'h00;
      ee_reg <= 8'h00;
      lim_reg <= SEA_STOP_G1;
      sig_lo_reg <= 8'h00;
      rgn_reg <= 4'h0;
      ackb_reg <= 1'b0;
      last_reg <= 1'b0;
      sig_reg <= 1'b0;
      nack_reg <= 1'b0;
      legacy_io_alias_wp_o <= 1'b0;
      load_done_o <= 1'b0;
      pend_reg <= 1'b1; // Load once after reset
      scl_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      eeprom_serial_data_oe_n_o <= 1'b1;
      eeprom_serial_data_o <= 1'b0;
      cfg_wr_o <= 1'b0;
      cfg_addr_o <= 8'h00;
      cfg_data_o <= 8'h00;
    end else begin
      st_reg <= st_next;
      sq_reg <= sq_next;
      q_reg <= q_next;
      div_reg <= div_next;
      bitn_reg <= bitn_next;
      sh_reg <= sh_next;
      ee_reg <= ee_next;
      lim_reg <= lim_next;
      sig_lo_reg <= sig_lo_next;
      rgn_reg <= rgn_next;
      ackb_reg <= ackb_next;
      last_reg <= last_next;
      sig_reg <= sig_next;
      nack_reg <= nack_next;
      legacy_io_alias_wp_o <= wp_next;
      load_done_o <= done_next;
      pend_reg <= pend_next;
      scl_o <= scl_next;
      scl_oe_n_o <= scl_oe_n_next;
      eeprom_serial_data_oe_n_o <= sda_oe_n_next;
      eeprom_serial_data_o <= 1'b0; // Open drain: only ever pulls low
      cfg_wr_o <= wr_next;
      cfg_addr_o <= caddr_next;
      cfg_data_o <= cdata_next;
    end
  end

  // Wishbone slave: one wait state, unmapped reads as zero
  logic [31:0] rd_next;
  logic ack_next;
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    go_next = ack_next & wb_we_i & wb_sel_i[0] & (wb_adr_i == SEA_REG_CTRL)
              & wb_dat_i[SEA_CTRL_GO];
    rd_next = 32'h0000_0000;
    if (wb_adr_i == SEA_REG_STATUS) begin
      rd_next[SEA_ST_BUSY] = (st_reg != SEA_IDLE);
      rd_next[SEA_ST_DONE] = load_done_o;
      rd_next[SEA_ST_SIG] = sig_reg;
      rd_next[SEA_ST_NACK] = nack_reg;
      rd_next[SEA_ST_MODE +: 2] = mode_reg;
      rd_next[SEA_ST_WP] = legacy_io_alias_wp_o;
      rd_next[SEA_ST_SMBCLK] = smbclk_s; // Bus slave clock level
      rd_next[SEA_ST_RGN +: 4] = rgn_reg;
    end else if (wb_adr_i == SEA_REG_LAST) begin
      rd_next[7:0] = ee_reg;
    end
  end
  // Register bus answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      go_reg <= 1'b0;
      mode_smbus_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_next;
      wb_dat_o <= rd_next;
      go_reg <= go_next;
      mode_smbus_o <= (mode_reg == SEA_MODE_SMB);
    end
  end

  // Checks
  logic [7:0] prev_wr_reg;
  logic seen_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg == SEA_IDLE) begin
      seen_reg <= 1'b0;
      prev_wr_reg <= 8'h00;
    end else if (cfg_wr_o) begin
      seen_reg <= 1'b1;
      prev_wr_reg <= ee_reg;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_done_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ee_mode_sel_a: assert property ($rose(cap_reg) |-> (mode_reg == SEA_MODE_EE)
    == ($past(strap_s) == SEA_STRAP_EE)) else $error("memory mode strap");
  smb_mode_sel_a: assert property ($rose(cap_reg) |-> (mode_reg == SEA_MODE_SMB)
    == ($past(strap_s) == SEA_STRAP_SMB)) else $error("bus mode strap");
  scl_drive_a: assert property ($past(mode_reg) == SEA_MODE_EE && cap_reg
    |-> !scl_oe_n_o) else $error("clock not driven");
  smb_release_a: assert property (mode_reg != SEA_MODE_EE |=> eeprom_serial_data_oe_n_o
    && scl_oe_n_o && !eeprom_serial_data_o) else $error("pins not released");
  sig_gate_a: assert property (cfg_wr_o |-> sig_reg && {sig_lo_reg} == SEA_SIG[7:0])
    else $error("write without signature");
  region_stop_a: assert property (cfg_wr_o |-> ee_reg <= lim_reg && ee_reg >= SEA_FIRST_CFG)
    else $error("write past region");
  wp_load_a: assert property ($rose(legacy_io_alias_wp_o) |-> ee_reg == SEA_MISC_ADDR)
    else $error("protect from wrong byte");
  ascend_order_a: assert property (cfg_wr_o && seen_reg |-> ee_reg == prev_wr_reg + 8'h01
    ##1 !cfg_wr_o) else $error("load out of order");
  wb_answer_a: assert property (wb_req_s |=> wb_done_s) else $error("bus ack timing");
endmodule // sea_autoload
`default_nettype wire

// ==== sea_eeprom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behavioural serial memory: acks address bytes, streams image bytes on reads
module sea_eeprom_model (
  // Board-level bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Refuse every byte when high
  input wire logic nack_i,
  // High pulls the data line low
  output logic pull_o
);
  logic [7:0] mem [0:255]; // Image, filled by the bench
  logic [7:0] sh; // Received byte
  logic [7:0] ptr; // Current byte address
  int cnt; // Clock pulses within the byte
  int nb; // Bytes since the last start
  logic tx; // Streaming to the master
  logic go_tx; // Read direction requested
  initial begin
    pull_o = 1'b0;
    cnt = 0;
    nb = 0;
    tx = 1'b0;
    go_tx = 1'b0;
    ptr = 8'h00;
  end
  // Start: data falls while clock high
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      cnt = 0;
      nb = 0;
      tx = 1'b0;
      go_tx = 1'b0;
    end
  end
  // Sample on rising clock; a high ninth bit ends a read
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (tx && sda_i) tx = 1'b0;
    cnt = cnt + 1;
  end
  // Drive only while clock low, so no false start or stop is made
  always @(negedge scl_i) begin
    if (cnt == 8 && !tx) begin
      pull_o = !nack_i;
      go_tx = (nb == 0) && sh[0];
      if (nb == 1) ptr = sh;
      nb = nb + 1;
    end else if (cnt == 8) begin
      pull_o = 1'b0;
    end else if (cnt == 9) begin
      cnt = 0;
      pull_o = 1'b0;
      if (tx) ptr = ptr + 8'h01;
      if (go_tx) tx = 1'b1;
      go_tx = 1'b0;
    end
    if (tx && cnt < 8) pull_o = !mem[ptr][7 - cnt];
  end
endmodule // sea_eeprom_model
`default_nettype wire

// ==== sea_pkg.sv ====
`default_nettype none
package sea_pkg;
  // Core clock and two-wire bit timing
  localparam int SEA_CLK_NS = 10;
  localparam int SEA_QTR_NS = 2500;
  localparam int SEA_QTR_CYC = (SEA_QTR_NS + SEA_CLK_NS - 1) / SEA_CLK_NS;
  // Strap codes {high, low}
  localparam logic [1:0] SEA_STRAP_EE = 2'h0;
  localparam logic [1:0] SEA_STRAP_SMB = 2'h1;
  // Serial memory device address bytes
  localparam logic [7:0] SEA_DEV_WR = 8'ha0;
  localparam logic [7:0] SEA_DEV_RD = 8'ha1;
  localparam logic [7:0] SEA_START_ADDR = 8'h00;
  // Image layout
  localparam logic [15:0] SEA_SIG = 16'h1516;
  localparam logic [7:0] SEA_SIG_HI_ADDR = 8'h01;
  localparam logic [7:0] SEA_REGION_ADDR = 8'h02;
  localparam logic [7:0] SEA_MISC_ADDR = 8'h03;
  localparam logic [7:0] SEA_FIRST_CFG = 8'h04;
  localparam logic [7:0] SEA_LAST_ADDR = 8'hff;
  localparam int SEA_REGION_LSB = 1;
  localparam int SEA_WP_BIT = 0;
  // Region codes and their stop addresses
  localparam logic [3:0] SEA_RGN_G1 = 4'h0;
  localparam logic [3:0] SEA_RGN_G2 = 4'h1;
  localparam logic [3:0] SEA_RGN_G3 = 4'h3;
  localparam logic [3:0] SEA_RGN_G4 = 4'h7;
  localparam logic [7:0] SEA_STOP_G1 = 8'h0b;
  localparam logic [7:0] SEA_STOP_G2 = 8'h67;
  localparam logic [7:0] SEA_STOP_G3 = 8'haf;
  localparam logic [7:0] SEA_STOP_G4 = 8'hd7;
  // Image to configuration offset map
  localparam logic [7:0] SEA_ID_END = 8'h07;
  localparam logic [7:0] SEA_ID_SHIFT = 8'h04;
  localparam logic [7:0] SEA_CAP_EE = 8'h0c;
  localparam logic [7:0] SEA_CAP_CFG = 8'h34;
  // Register offsets and status bits
  localparam logic [7:0] SEA_REG_CTRL = 8'h00;
  localparam logic [7:0] SEA_REG_STATUS = 8'h04;
  localparam logic [7:0] SEA_REG_LAST = 8'h08;
  localparam int SEA_CTRL_GO = 0;
  localparam int SEA_ST_BUSY = 0;
  localparam int SEA_ST_DONE = 1;
  localparam int SEA_ST_SIG = 2;
  localparam int SEA_ST_NACK = 3;
  localparam int SEA_ST_MODE = 4;
  localparam int SEA_ST_WP = 6;
  localparam int SEA_ST_SMBCLK = 7;
  localparam int SEA_ST_RGN = 8;
  // Modes and states
  typedef enum logic [1:0] {SEA_MODE_NONE = 2'h0, SEA_MODE_EE = 2'h1,
                            SEA_MODE_SMB = 2'h2} sea_mode_t;
  typedef enum logic [2:0] {SEA_IDLE = 3'h0, SEA_START = 3'h1, SEA_BIT = 3'h3,
                            SEA_STOP = 3'h2, SEA_DONE = 3'h6} sea_state_t;
  typedef enum logic [1:0] {SEA_SQ_DEVW = 2'h0, SEA_SQ_WADR = 2'h1, SEA_SQ_DEVR = 2'h3,
                            SEA_SQ_READ = 2'h2} sea_step_t;
endpackage
`default_nettype wire

// ==== sea_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser; first stage feeds only the second
module sea_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg; // First stage
  // Register both stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // sea_sync2
`default_nettype wire

// ==== tb_serial_eeprom_config_autoload.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_config_autoload;
  import sea_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, st_hi, st_lo, link_clk, nack;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, st;
  logic wb_ack_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n, cfg_wr_o, done_o, wp_o, smb_o, pull;
  logic [7:0] cfg_addr_o, cfg_data_o;
  wire logic scl_line, sda_line;
  logic [15:0] wq[$]; // Captured config writes
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // Pull-ups on both lines when released
  assign scl_line = scl_oe_n_o ? 1'b1 : scl_o;
  assign sda_line = ((!sda_oe_n && !sda_o) || pull) ? 1'b0 : 1'b1;
  sea_autoload #(.QTR_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .iface_select_strap_high_i(st_hi), .iface_select_strap_low_i(st_lo),
    .smbclk_i(link_clk), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .eeprom_serial_data_i(sda_line), .eeprom_serial_data_o(sda_o),
    .eeprom_serial_data_oe_n_o(sda_oe_n), .cfg_wr_o(cfg_wr_o), .cfg_addr_o(cfg_addr_o),
    .cfg_data_o(cfg_data_o), .load_done_o(done_o), .legacy_io_alias_wp_o(wp_o),
    .mode_smbus_o(smb_o));
  sea_eeprom_model eep (.scl_i(scl_line), .sda_i(sda_line), .nack_i(nack), .pull_o(pull));
  always #5 clk_i = ~clk_i;
  // Record writes; cut a hang short
  always @(posedge clk_i) begin
    if (cfg_wr_o === 1'b1) wq.push_back({cfg_addr_o, cfg_data_o});
    cycles = cycles + 1;
    if (cycles == 90000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    t = 0;
    do begin
      @(posedge clk_i);
      t = t + 1;
    end while (wb_ack_o !== 1'b1);
    st = wb_dat_o;
    chk(t, 2);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    rst_i <= 1'b1;
    {st_hi, st_lo} <= s;
    tick(12);
    chk({scl_o, scl_oe_n_o, sda_oe_n, cfg_wr_o}, 4'he);
    rst_i <= 1'b0;
  endtask
  // Wait for done to drop (restart) and rise again
  task automatic wait_load();
    int t;
    t = 0;
    while (done_o === 1'b1 && t < 20) begin
      tick(1);
      t = t + 1;
    end
    t = 0;
    while (done_o !== 1'b1 && t < 40000) begin
      tick(1);
      t = t + 1;
    end
    chk(done_o, 1);
  endtask
  // Good image with a region code; first load starts from reset
  task automatic t_load(input logic [3:0] code, input logic wp, input logic first);
    logic [7:0] stp, a, ea;
    for (int i = 4; i < 256; i++) eep.mem[i] = i[7:0] ^ 8'h5a;
    eep.mem[0] = 8'h16;
    eep.mem[1] = 8'h15;
    eep.mem[2] = {3'h0, code, 1'b0};
    eep.mem[3] = {7'h00, wp};
    wq.delete();
    if (first) do_reset(SEA_STRAP_EE);
    else wb(1'b1, SEA_REG_CTRL, 32'h0000_0001, 4'h1);
    wait_load();
    stp = (code == 4'h1) ? 8'h67 : (code == 4'h3) ? 8'haf : (code == 4'h7) ? 8'hd7 : 8'h0b;
    chk(wq.size(), stp - 8'h03);
    for (int i = 0; i < wq.size(); i++) begin
      a = i[7:0] + 8'h04;
      ea = (a < 8'h08) ? a - 8'h04 : (a == 8'h0c) ? 8'h34 : a;
      chk(wq[i], {ea, a ^ 8'h5a});
    end
    chk({wp_o, smb_o, scl_oe_n_o}, {wp, 2'h0});
    wb(1'b0, SEA_REG_STATUS, 32'h0, 4'hf);
    chk(st & 32'hffff_ff7f, {20'h0, code, 1'b0, wp, 6'h16});
    wb(1'b0, SEA_REG_LAST, 32'h0, 4'hf);
    chk(st, {24'h0, stp});
  endtask
  // Swapped signature bytes: no writes
  task automatic t_bad_sig();
    eep.mem[0] = 8'h15;
    eep.mem[1] = 8'h16;
    wq.delete();
    wb(1'b1, SEA_REG_CTRL, 32'h0000_0001, 4'h1);
    wait_load();
    chk(wq.size(), 0);
    wb(1'b0, SEA_REG_STATUS, 32'h0, 4'hf);
    chk(st[3:1], 3'h1);
  endtask
  // Memory refuses its address
  task automatic t_nack();
    eep.mem[0] = 8'h16;
    eep.mem[1] = 8'h15;
    nack = 1'b1;
    wq.delete();
    wb(1'b1, SEA_REG_CTRL, 32'h0000_0001, 4'h1);
    wait_load();
    nack = 1'b0;
    chk(wq.size(), 0);
    wb(1'b0, SEA_REG_STATUS, 32'h0, 4'hf);
    chk(st[3], 1);
  endtask
  // Slave mode: pins released, clock level followed
  task automatic t_smbus();
    do_reset(SEA_STRAP_SMB);
    tick(6);
    chk({smb_o, scl_oe_n_o, sda_oe_n, sda_line}, 4'hf);
    for (int i = 0; i < 4; i++) begin
      link_clk <= ~link_clk;
      tick(5);
      wb(1'b0, SEA_REG_STATUS, 32'h0, 4'hf);
      chk(st[7:4], {link_clk, 3'h2});
    end
    wq.delete();
    wb(1'b1, SEA_REG_CTRL, 32'h0000_0001, 4'h1);
    tick(60);
    chk(wq.size(), 0);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    chk(st, 0);
    do_reset(2'h2);
    tick(6);
    wb(1'b0, SEA_REG_STATUS, 32'h0, 4'hf);
    chk({smb_o, st[5:4]}, 0);
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    st_hi = 1'b0;
    st_lo = 1'b0;
    link_clk = 1'b1;
    nack = 1'b0;
    t_load(4'h0, 1'b1, 1'b1);
    t_load(4'h1, 1'b0, 1'b0);
    t_load(4'h3, 1'b1, 1'b0);
    t_load(4'h7, 1'b0, 1'b0);
    t_load(4'h2, 1'b0, 1'b0);
    t_bad_sig();
    t_nack();
    t_smbus();
    close_out();
  end
endmodule // tb_serial_eeprom_config_autoload
`default_nettype wire
